//--- src/ssr_top.sv
// Purpose: safe state reaction on heartbeat, reset out and window wd
// Assumes: one 20 MHz clock, synchronous active-high reset, APB slave
// Notes: safe state is latched until software writes CMD bit 0
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] Heartbeat stuck low: error once low-frequency time passes since last fall.
// [R2] Heartbeat stuck high: error once low-frequency time passes since last rise.
// [R3] Edge-to-edge interval shorter than high-frequency time is an error.
// [R4] Any duty cycle accepted; a pulse longer than low-frequency time errs.
// [R5] Immediate mode: primary output low at once, secondary after its delay.
// [R6] Recovery mode: interrupt, wait recovery delay, then primary low.
// [R7] Valid toggling before recovery expiry keeps both outputs high.
// [R8] Falling edge of reset_out is an error; primary low at once.
// [R9] Soft reset: secondary low after the programmed secondary delay.
// [R10] Hard reset: secondary low together with primary.
// [R11] Fail count rises by two per bad trigger, falls by one per good.
// [R12] Fail count saturates at zero.
// [R13] Each fail count increase raises an interrupt; decreases do not.
// [R14] Threshold writable only in INIT, NORMAL or WAKE state.
// [R15] Count at or above threshold drives both outputs low.
// [R16] Threshold hit: primary falls with count change, secondary delayed.
// [R17] Low-frequency time 50.1..99.9 us, high-frequency 5.2..11.1 us.
// [R18] Recovery delay selectable as 0, 1.0, 2.5, 5.0 or 10 ms.
// [R19] All delays count one time base; pulse timer restarts per edge.
module ssr_top #(
	parameter int P_TICK_CYC = ssr_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Heartbeat pin and reset output pin level
	input wire logic i_mcu_fault_manager,
	input wire logic i_reset_out,
	// Device control side, same clock
	input wire logic i_hard_reset,
	input wire logic [2:0] i_dev_state,
	input wire logic i_wwd_trig_ok,
	input wire logic i_wwd_trig_bad,
	// Safe state pins, active low; window watchdog fault and interrupt, active high
	output logic o_safe_state_out_primary_n,
	output logic o_safe_state_out_secondary_n,
	output logic o_window_wd_fault_out,
	output logic o_irq
);
	localparam int TW = ssr_pkg::TMR_W;
	localparam int CW = ssr_pkg::CNT_W;

	if (P_TICK_CYC < 1 || P_TICK_CYC > 65535) begin : g_chk
		$error("ssr_top: P_TICK_CYC out of range");
	end

	typedef enum logic [0:0] {
		SSR_REC_IDLE,
		SSR_REC_WAIT
	} ssr_rec_t;

	// Time base
	logic [15:0] div_q;
	logic tick_q;

	// Heartbeat
	logic hb_s1_q, hb_s2_q, hb_s3_q;
	logic hb_seen_q;
	logic [TW-1:0] hb_tmr_q;
	logic hb_edge, hb_fast, hb_slow, hb_err, hb_valid;
	logic hb_bad_q;

	// Recovery
	ssr_rec_t rec_q;
	logic [TW-1:0] rec_cnt_q;
	logic hb_trip;

	// Reset out
	logic rot_s1_q, rot_s2_q, rot_s3_q;
	logic rot_fall;

	// Window watchdog counter
	logic [CW-1:0] cnt_q, cnt_d;
	logic [CW-1:0] thr_q;
	logic thr_hit;

	// Safe state
	logic ss1_q, ss2_q;
	logic ss2_pend_q;
	logic [TW-1:0] ss2_cnt_q;
	logic trip, trip_hard;

	// Registers
	logic [7:0] ctrl_q;
	logic [IRQ_N_W-1:0] irq_stat_q, irq_mask_q;
	localparam int IRQ_N_W = ssr_pkg::IRQ_N;
	logic [IRQ_N_W-1:0] irq_set;
	logic wr, rd, access, release_cmd;
	logic [TW-1:0] rec_dly, ss2_dly;
	logic [31:0] rdata;
	logic hit;

	// One time base for every delay (see [R19])
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q == 16'(P_TICK_CYC - 1)) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			hb_s1_q <= 1'b0;
			hb_s2_q <= 1'b0;
			hb_s3_q <= 1'b0;
			rot_s1_q <= 1'b1;
			rot_s2_q <= 1'b1;
			rot_s3_q <= 1'b1;
		end else begin
			hb_s1_q <= i_mcu_fault_manager;
			hb_s2_q <= hb_s1_q;
			hb_s3_q <= hb_s2_q;
			rot_s1_q <= i_reset_out;
			rot_s2_q <= rot_s1_q;
			rot_s3_q <= rot_s2_q;
		end
	end

	assign hb_edge = ctrl_q[ssr_pkg::C_HB_EN] & (hb_s2_q ^ hb_s3_q);
	// First edge after enable has no interval to judge
	assign hb_fast = hb_edge & hb_seen_q
		& (hb_tmr_q < ssr_pkg::HB_HF_TK); // see [R3] [R17]
	// Fires once when the pulse timer reaches the limit
	assign hb_slow = ctrl_q[ssr_pkg::C_HB_EN] & tick_q & ~hb_edge
		& (hb_tmr_q == ssr_pkg::HB_LF_TK - 18'h00001); // see [R1] [R2] [R4]
	assign hb_err = hb_fast | hb_slow;
	assign hb_valid = hb_edge & hb_seen_q & ~hb_fast
		& (hb_tmr_q < ssr_pkg::HB_LF_TK); // see [R4]

	// Pulse timer measured from the last recognized edge of either kind
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !ctrl_q[ssr_pkg::C_HB_EN]) begin
			hb_tmr_q <= '0;
			hb_seen_q <= 1'b0;
		end else if (hb_edge) begin
			hb_tmr_q <= '0; // see [R19] [R1] [R2]
			hb_seen_q <= 1'b1;
		end else if (tick_q && hb_tmr_q != ssr_pkg::HB_LF_TK) begin
			hb_tmr_q <= hb_tmr_q + 18'h00001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			hb_bad_q <= 1'b0;
		end else if (hb_err) begin
			hb_bad_q <= 1'b1;
		end else if (hb_valid) begin
			hb_bad_q <= 1'b0;
		end
	end

	// Recovery delay selection, codes above 4 clamp to 10 ms
	always_comb begin
		case (ctrl_q[ssr_pkg::C_REC_SEL +: 3])
			3'h0: rec_dly = ssr_pkg::REC_0; // see [R18]
			3'h1: rec_dly = ssr_pkg::REC_1;
			3'h2: rec_dly = ssr_pkg::REC_2;
			3'h3: rec_dly = ssr_pkg::REC_3;
			default: rec_dly = ssr_pkg::REC_4;
		endcase
	end

	always_comb begin
		case (ctrl_q[ssr_pkg::C_SS2_SEL +: 3])
			3'h0: ss2_dly = ssr_pkg::SS2_0;
			3'h1: ss2_dly = ssr_pkg::SS2_1;
			3'h2: ss2_dly = ssr_pkg::SS2_2;
			3'h3: ss2_dly = ssr_pkg::SS2_3;
			default: ss2_dly = ssr_pkg::SS2_4;
		endcase
	end

	// Heartbeat trip: immediate, or after an uncancelled recovery wait
	always_comb begin
		hb_trip = 1'b0;
		case (rec_q)
			SSR_REC_IDLE: begin
				hb_trip = hb_err & (~ctrl_q[ssr_pkg::C_REC_MODE]
					| (rec_dly == '0)); // see [R5]
			end
			SSR_REC_WAIT: begin
				hb_trip = tick_q & (rec_cnt_q == 18'h00001)
					& ~hb_valid; // see [R6]
			end
			default: hb_trip = 1'b0;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rec_q <= SSR_REC_IDLE;
			rec_cnt_q <= '0;
		end else begin
			case (rec_q)
				SSR_REC_IDLE: begin
					if (hb_err && ctrl_q[ssr_pkg::C_REC_MODE]
						&& rec_dly != '0) begin
						rec_q <= SSR_REC_WAIT; // see [R6]
						rec_cnt_q <= rec_dly;
					end
				end
				SSR_REC_WAIT: begin
					if (hb_valid) begin
						// Heartbeat back in time: no safe state
						rec_q <= SSR_REC_IDLE; // see [R7]
					end else if (tick_q) begin
						rec_cnt_q <= rec_cnt_q - 18'h00001;
						if (rec_cnt_q == 18'h00001) begin
							rec_q <= SSR_REC_IDLE;
						end
					end
				end
				default: rec_q <= SSR_REC_IDLE;
			endcase
		end
	end

	assign rot_fall = rot_s3_q & ~rot_s2_q; // see [R8]

	// Failure counter, saturating at both ends
	always_comb begin
		cnt_d = cnt_q;
		if (i_wwd_trig_bad) begin
			if (cnt_q > CW'({CW{1'b1}} - 2)) begin
				cnt_d = '1;
			end else begin
				cnt_d = cnt_q + CW'(2); // see [R11]
			end
		end else if (i_wwd_trig_ok && cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1); // see [R11] [R12]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Compare the next count so the primary falls with the change
	assign thr_hit = (cnt_d >= thr_q) & (cnt_d != cnt_q); // see [R15] [R16]

	assign trip = hb_trip | rot_fall | thr_hit;
	assign trip_hard = rot_fall & i_hard_reset;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ss1_q <= 1'b1;
		end else if (trip) begin
			ss1_q <= 1'b0; // see [R5] [R8] [R15] [R16]
		end else if (release_cmd) begin
			ss1_q <= 1'b1;
		end
	end

	// Secondary output: own delay, or with primary on hard reset
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ss2_q <= 1'b1;
			ss2_pend_q <= 1'b0;
			ss2_cnt_q <= '0;
		end else if (trip_hard) begin
			ss2_q <= 1'b0; // see [R10]
			ss2_pend_q <= 1'b0;
		end else if (trip && ss1_q && ss2_q && !ss2_pend_q) begin
			if (ss2_dly == '0) begin
				ss2_q <= 1'b0;
			end else begin
				ss2_pend_q <= 1'b1; // see [R9] [R5] [R16]
				ss2_cnt_q <= ss2_dly;
			end
		end else if (release_cmd && !trip) begin
			ss2_q <= 1'b1;
			ss2_pend_q <= 1'b0;
		end else if (ss2_pend_q && tick_q) begin
			ss2_cnt_q <= ss2_cnt_q - 18'h00001;
			if (ss2_cnt_q == 18'h00001) begin
				ss2_q <= 1'b0; // see [R9]
				ss2_pend_q <= 1'b0;
			end
		end
	end

	// APB: one wait state, so every answer comes from a flip-flop
	assign access = i_psel & i_penable & ~o_pready;
	assign wr = access & i_pwrite;
	assign rd = access & ~i_pwrite;
	assign release_cmd = wr & (i_paddr == ssr_pkg::A_CMD) & i_pwdata[0];

	always_comb begin
		hit = 1'b1;
		rdata = 32'h00000000;
		case (i_paddr)
			ssr_pkg::A_CTRL: rdata[7:0] = ctrl_q;
			ssr_pkg::A_THR: rdata[CW-1:0] = thr_q;
			ssr_pkg::A_STAT: begin
				rdata[0] = ss1_q;
				rdata[1] = ss2_q;
				rdata[2] = hb_bad_q;
				rdata[3] = (rec_q == SSR_REC_WAIT);
				rdata[8 +: CW] = cnt_q;
			end
			ssr_pkg::A_IRQ: rdata[IRQ_N_W-1:0] = irq_stat_q;
			ssr_pkg::A_MASK: rdata[IRQ_N_W-1:0] = irq_mask_q;
			ssr_pkg::A_CMD: rdata = 32'h00000000;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= access;
			o_pslverr <= access & ~hit;
			o_prdata <= (rd && hit) ? rdata : 32'h00000000;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctrl_q <= ssr_pkg::CTRL_RST;
			irq_mask_q <= '0;
		end else if (wr) begin
			if (i_paddr == ssr_pkg::A_CTRL) begin
				ctrl_q <= i_pwdata[7:0];
			end
			if (i_paddr == ssr_pkg::A_MASK) begin
				irq_mask_q <= i_pwdata[IRQ_N_W-1:0];
			end
		end
	end

	// Threshold write silently dropped outside the allowed states
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			thr_q <= ssr_pkg::THR_RST;
		end else if (wr && i_paddr == ssr_pkg::A_THR
			&& (i_dev_state == ssr_pkg::ST_INIT
			|| i_dev_state == ssr_pkg::ST_NORMAL
			|| i_dev_state == ssr_pkg::ST_WAKE)) begin
			thr_q <= i_pwdata[CW-1:0]; // see [R14]
		end
	end

	always_comb begin
		irq_set = '0;
		irq_set[ssr_pkg::I_HB] = hb_err; // see [R6]
		irq_set[ssr_pkg::I_WWD] = (cnt_d > cnt_q); // see [R13]
		irq_set[ssr_pkg::I_ROT] = rot_fall;
		irq_set[ssr_pkg::I_THR] = thr_hit;
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			irq_stat_q <= '0;
			o_irq <= 1'b0;
		end else begin
			if (wr && i_paddr == ssr_pkg::A_IRQ) begin
				irq_stat_q <= (irq_stat_q & ~i_pwdata[IRQ_N_W-1:0])
					| irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
			o_irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_safe_state_out_primary_n <= 1'b1;
			o_safe_state_out_secondary_n <= 1'b1;
			o_window_wd_fault_out <= 1'b0;
		end else begin
			o_safe_state_out_primary_n <= ss1_q;
			o_safe_state_out_secondary_n <= ss2_q;
			o_window_wd_fault_out <= (cnt_q >= thr_q);
		end
	end
endmodule
`default_nettype wire

//--- src/ssr_pkg.sv
// Purpose: constants of the safe state reaction block
// Assumes: 20 MHz clock, 1 us time base tick
// Notes: register map at APB byte addresses
package ssr_pkg;
	localparam int CLK_NS = 50;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	// Detection times in us, inside the allowed bands
	localparam int HB_LF_US = 75;
	localparam int HB_HF_US = 8;
	localparam int TMR_W = 18;
	localparam logic [TMR_W-1:0] HB_LF_TK = 18'h0004B;
	localparam logic [TMR_W-1:0] HB_HF_TK = 18'h00008;
	// Recovery delay table in us: 0, 1.0, 2.5, 5.0, 10 ms
	localparam logic [TMR_W-1:0] REC_0 = 18'h00000;
	localparam logic [TMR_W-1:0] REC_1 = 18'h003E8;
	localparam logic [TMR_W-1:0] REC_2 = 18'h009C4;
	localparam logic [TMR_W-1:0] REC_3 = 18'h01388;
	localparam logic [TMR_W-1:0] REC_4 = 18'h02710;
	// Secondary delay table in us: 0, 10, 50, 100, 250 ms
	localparam logic [TMR_W-1:0] SS2_0 = 18'h00000;
	localparam logic [TMR_W-1:0] SS2_1 = 18'h02710;
	localparam logic [TMR_W-1:0] SS2_2 = 18'h0C350;
	localparam logic [TMR_W-1:0] SS2_3 = 18'h186A0;
	localparam logic [TMR_W-1:0] SS2_4 = 18'h3D090;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_THR = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_IRQ = 8'h0C;
	localparam logic [7:0] A_MASK = 8'h10;
	localparam logic [7:0] A_CMD = 8'h14;
	// CTRL fields
	localparam int C_REC_MODE = 0;
	localparam int C_REC_SEL = 1;
	localparam int C_SS2_SEL = 4;
	localparam int C_HB_EN = 7;
	localparam logic [7:0] CTRL_RST = 8'h80;
	// Interrupt bits
	localparam int IRQ_N = 4;
	localparam int I_HB = 0;
	localparam int I_WWD = 1;
	localparam int I_ROT = 2;
	localparam int I_THR = 3;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] THR_RST = 5'h09;
	// Device state codes seen on i_dev_state
	localparam logic [2:0] ST_INIT = 3'h0;
	localparam logic [2:0] ST_NORMAL = 3'h1;
	localparam logic [2:0] ST_WAKE = 3'h2;
endpackage

//--- tb/ssr_props.sv
// Purpose: port checks of the safe state reaction block
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every ssr_top instance
`timescale 1ns/1ps
`default_nettype none
module ssr_props (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	// Pins and device side
	input wire logic i_mcu_fault_manager,
	input wire logic i_reset_out,
	input wire logic i_hard_reset,
	input wire logic [2:0] i_dev_state,
	input wire logic i_wwd_trig_ok,
	input wire logic i_wwd_trig_bad,
	input wire logic o_safe_state_out_primary_n,
	input wire logic o_safe_state_out_secondary_n,
	input wire logic o_window_wd_fault_out,
	input wire logic o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic cmd_wr;
	assign cmd_wr = i_psel && i_pwrite && i_paddr == ssr_pkg::A_CMD;
	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("pready not one cycle after access");
	a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
		else $error("read data or error outside answer");
	a_rot_primary: assert property ($fell(i_reset_out) |-> ##[1:8]
		!o_safe_state_out_primary_n) else $error("primary late on reset fall");
	a_thr_primary: assert property ($rose(o_window_wd_fault_out) |->
		##[0:3] !o_safe_state_out_primary_n) else $error("primary late on trip");
	a_sec_after_pri: assert property ($fell(o_safe_state_out_secondary_n) |->
		!o_safe_state_out_primary_n) else $error("secondary before primary");
	a_hard_together: assert property ($fell(o_safe_state_out_primary_n) &&
		i_hard_reset |-> !o_safe_state_out_secondary_n) else $error("secondary apart");
	a_pri_release: assert property ($rose(o_safe_state_out_primary_n) |->
		$past(cmd_wr, 1) || $past(cmd_wr, 2) || $past(cmd_wr, 3))
		else $error("primary released without command");
endmodule
bind ssr_top ssr_props props_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_reset_out(i_reset_out),
	.i_mcu_fault_manager(i_mcu_fault_manager), .i_hard_reset(i_hard_reset),
	.i_dev_state(i_dev_state), .i_wwd_trig_ok(i_wwd_trig_ok),
	.i_wwd_trig_bad(i_wwd_trig_bad), .o_irq(o_irq),
	.o_safe_state_out_primary_n(o_safe_state_out_primary_n),
	.o_safe_state_out_secondary_n(o_safe_state_out_secondary_n),
	.o_window_wd_fault_out(o_window_wd_fault_out));
`default_nettype wire

//--- tb/ssr_hb_model.sv
// Purpose: fault manager heartbeat source
// Assumes: pulse length in clock cycles from the bench
// Notes: holds its level when stopped, like a stuck fault manager
`timescale 1ns/1ps
`default_nettype none
module ssr_hb_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Bench control
	input wire logic i_run,
	input wire logic [7:0] i_half,
	// Heartbeat pin
	output logic o_hb
);
	logic [7:0] cnt_q;
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run) begin
			cnt_q <= 8'h00;
		end else if (cnt_q + 8'h01 >= i_half) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_hb <= 1'b0;
		end else if (i_run && cnt_q + 8'h01 >= i_half) begin
			o_hb <= ~o_hb;
		end
	end
endmodule
`default_nettype wire

//--- tb/ssr_tb.sv
// Purpose: self-checking bench of the safe state reaction block
// Assumes: one-cycle time base tick so every delay is in cycles
// Notes: random pulse lengths and trigger kinds, seed fixed
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic reset_out = 1'b1;
	logic hard = 1'b0;
	logic [2:0] dstate = 3'h1;
	logic ok = 1'b0;
	logic bad = 1'b0;
	logic run = 1'b0;
	logic [7:0] half = 8'h1E;
	logic hb, pready, err, pri, sec, fault, irq, b;
	logic [31:0] prdata, q;
	logic [4:0] e;
	int fail_count = 0;
	int comparisons = 0;
	int n;
	always #25 clk = ~clk;
	ssr_hb_model hb_u (.i_clk(clk), .i_rst(srst), .i_run(run), .i_half(half),
		.o_hb(hb));
	ssr_top #(.P_TICK_CYC(1)) dut_u (.i_ref_clk(clk), .i_srst(srst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(err), .i_mcu_fault_manager(hb), .i_reset_out(reset_out),
		.i_hard_reset(hard), .i_dev_state(dstate), .i_wwd_trig_ok(ok),
		.i_wwd_trig_bad(bad), .o_safe_state_out_primary_n(pri),
		.o_safe_state_out_secondary_n(sec), .o_window_wd_fault_out(fault),
		.o_irq(irq));
	task print_verdict;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task give_up(input string s);
		fail_count++;
		$display("ERROR timeout %s", s);
		print_verdict();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) give_up("pready");
		q = prdata;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(nm, x, q & m)
	endtask
	// Leaves safe state by writing CMD bit 0, whether or not the error cause is gone, then clears all interrupt flags
	task rel;
		apb(1'b1, ssr_pkg::A_CMD, 32'h1);
		apb(1'b1, ssr_pkg::A_IRQ, 32'hF);
	endtask
	task wait_low(input logic s, input int mx);
		n = 0;
		while ((s ? sec : pri) !== 1'b0) begin
			@(negedge clk);
			n++;
			if (n > mx) give_up("safe state");
		end
	endtask
	// Stops just after an edge into lv so the stuck time is known
	task hb_stop(input logic lv);
		int k;
		k = 0;
		while (hb !== ~lv && k < 300) begin @(negedge clk); k++; end
		while (hb !== lv && k < 300) begin @(negedge clk); k++; end
		if (k >= 300) give_up("edge");
		@(posedge clk);
		run <= 1'b0;
	endtask
	initial begin
		n = $urandom(37);
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd_chk("ctrl", ssr_pkg::A_CTRL, 32'hFF, 32'h80);
		rd_chk("mask", ssr_pkg::A_MASK, 32'hF, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		`CHK("unmapped", 1'b1, err)
		for (int lv = 0; lv < 2; lv++) begin
			run <= 1'b1;
			repeat (15) begin
				half <= 8'h0A + 8'($urandom % 56);
				repeat (40) @(posedge clk);
			end
			`CHK("valid pulses", 1'b1, pri)
			hb_stop(lv[0]);
			wait_low(1'b0, 200);
			`CHK("stuck time", 1'b1, n >= 72 && n <= 86)
			@(negedge clk);
			`CHK("sec immediate", 1'b0, sec)
			half <= 8'h1E;
			run <= 1'b1;
			repeat (200) @(posedge clk);
			rel;
		end
		half <= 8'h04;
		wait_low(1'b0, 60);
		`CHK("fast time", 1'b1, n <= 20)
		half <= 8'h1E;
		repeat (200) @(posedge clk);
		rel;
		apb(1'b1, ssr_pkg::A_CTRL, 32'h83);
		hb_stop(1'b0);
		repeat (300) @(posedge clk);
		rd_chk("rec irq", ssr_pkg::A_IRQ, 32'h1, 32'h1);
		`CHK("rec wait", 1'b1, pri)
		run <= 1'b1;
		repeat (1500) @(posedge clk);
		`CHK("rec cancel", 2'b11, {pri, sec})
		hb_stop(1'b1);
		wait_low(1'b0, 1300);
		`CHK("rec time", 1'b1, n >= 1068 && n <= 1092)
		apb(1'b1, ssr_pkg::A_CTRL, 32'h10);
		run <= 1'b1;
		rel;
		for (int h = 0; h < 2; h++) begin
			hard <= h[0];
			reset_out <= 1'b0;
			wait_low(1'b0, 20);
			`CHK("rot time", 1'b1, n <= 8)
			@(negedge clk);
			`CHK("sec at fall", ~h[0], sec)
			if (h == 0) begin
				repeat (9000) @(negedge clk);
				`CHK("sec early", 1'b1, sec)
				wait_low(1'b1, 1100);
				`CHK("sec delay", 1'b1, n >= 990 && n <= 1010)
			end
			reset_out <= 1'b1;
			hard <= 1'b0;
			repeat (10) @(posedge clk);
			rel;
		end
		apb(1'b1, ssr_pkg::A_MASK, 32'h2);
		dstate <= 3'h3;
		apb(1'b1, ssr_pkg::A_THR, 32'h5);
		rd_chk("thr locked", ssr_pkg::A_THR, 32'h1F, 32'h9);
		dstate <= 3'h1;
		apb(1'b1, ssr_pkg::A_THR, 32'h6);
		e = 5'h00;
		for (int i = 0; e < 5'h06 && i < 40; i++) begin
			b = (i >= 2) && $urandom % 2;
			apb(1'b1, ssr_pkg::A_IRQ, 32'hF);
			@(posedge clk);
			bad <= b;
			ok <= ~b;
			@(posedge clk);
			bad <= 1'b0;
			ok <= 1'b0;
			e = b ? e + 5'h02 : (e > 5'h00 ? e - 5'h01 : 5'h00);
			rd_chk("count", ssr_pkg::A_STAT, 32'h1F00, 32'(e) << 8);
			rd_chk("inc irq", ssr_pkg::A_IRQ, 32'h2, 32'(b) << 1);
			`CHK("irq pin", b, irq)
			`CHK("fault", e >= 5'h06, fault)
		end
		`CHK("trip outputs", 2'b01, {pri, sec})
		rd_chk("trip irq", ssr_pkg::A_IRQ, 32'h8, 32'h8);
		print_verdict();
	end
endmodule
`default_nettype wire
